// file: ied_defs.svh
// Purpose: Shared constants of the integer execution datapath.
// Assumes: Included by the package and by the ied_datapath module.
// Notes: Definitions only; no logic lives here.
// ==========================================================================
// Overview of operation
// - multiply_accumulate: a*b+c, 32 bits, flags kept.
// - multiply_subtract: c-a*b, 32 bits, flags kept.
// - signed_wide_product: signed a*b, 64 bits over lo/hi.
// - signed_wide_accumulate: hi:lo plus signed a*b, 64 bits.
// - unsigned_wide_double_accumulate: unsigned a*b+lo+hi, 64 bits.
// - byte_swap_word reverses all four bytes.
// - halfword_byte_swap swaps bytes within each half.
// - low_half_swap_sign_extend swaps low-half bytes, sign-extends.
// - signed_field_extract: lsb/width field, sign-extended.
// - unsigned_field_extract: lsb/width field, zero-extended.
// - half_sign_widen: optional rotate, sign-extend low half.
// - half_zero_widen: optional rotate, zero-extend low half.
// - write_special_register copies a register in; status sets NZCV.
// - read_special_register copies one out, flags kept.
// - multi_load_descending loads list below base, optional writeback.
// - multi_store_descending stores list below base, optional writeback.
// - exclusive_half_load reads halfword at base, marks it.
// - exclusive_half_store writes halfword, returns pass/fail word.
// - wide_constant_move loads imm16; flag form sets only N and Z.
`ifndef IED_DEFS_SVH
`define IED_DEFS_SVH

// ==========================================================================
// Widths and encodings
`define IED_XLEN 32
`define IED_WORD_BYTES 32'h0000_0004
`define IED_SPEC_STATUS 2'h0
`define IED_SPEC_PRIMASK 2'h1
`define IED_SPEC_CONTROL 2'h2
`define IED_SIZE_HALF 2'h1
`define IED_SIZE_WORD 2'h2
`define IED_EXCL_PASS 32'h0000_0000
`define IED_EXCL_FAIL 32'h0000_0001

// ==========================================================================
// Reset values
`define IED_FLAGS_RST 4'h0
`define IED_PRIMASK_RST 1'h0
`define IED_CONTROL_RST 2'h0

`endif

// file: ied_pkg.sv
// Purpose: Types shared by the integer execution datapath.
// Assumes: ied_defs.svh is on the include path.
// Notes: Constants stay in the header; only types live here.
`include "ied_defs.svh"

package ied_pkg;

    // ======================================================================
    // Operation selector.
    typedef enum logic [4:0] {
        OP_NOP, OP_MAC, OP_MSUB, OP_SWPROD, OP_SWACC, OP_UWDACC,
        OP_BSWAP, OP_HBSWAP, OP_LHSWAP, OP_SFX, OP_UFX, OP_HSWIDEN,
        OP_HZWIDEN, OP_WSPEC, OP_RSPEC, OP_MLOAD, OP_MSTORE, OP_XLOAD,
        OP_XSTORE, OP_WCMOVE
    } ied_op_t;

    // ======================================================================
    // One request from the decoder with its operand values.
    typedef struct packed {
        ied_op_t op;
        logic set_flags;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        logic [31:0] d;
        logic [4:0] lsb;
        logic [5:0] width;
        logic [1:0] rot;
        logic [15:0] imm16;
        logic [1:0] spec_sel;
        logic [15:0] reglist;
        logic wback;
        logic [3:0] base_idx;
        logic [3:0] dst_lo;
        logic [3:0] dst_hi;
    } ied_req_t;

    // ======================================================================
    // Register file write-back, two ports.
    typedef struct packed {
        logic wr_lo;
        logic wr_hi;
        logic [3:0] idx_lo;
        logic [3:0] idx_hi;
        logic [31:0] data_lo;
        logic [31:0] data_hi;
    } ied_res_t;

    // Memory request towards the load/store port.
    typedef struct packed {
        logic req;
        logic we;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ied_mem_t;

endpackage

// file: ied_mac.sv
// Purpose: 32x32 multiplier with 64-bit accumulate or subtract.
// Assumes: Caller prepares the 64-bit addend for each multiply form.
// Notes: Purely combinational; the caller registers the sum.
`timescale 1ns/1ps
`default_nettype none

module ied_mac (
    input wire logic [31:0] a,
    input wire logic [31:0] b,
    input wire logic [63:0] acc,
    input wire logic is_signed,
    input wire logic subtract,
    output logic [63:0] sum
);

    // ======================================================================
    // Product
    logic [65:0] prod_full;
    logic [63:0] prod;

    // One extra sign bit per operand lets one multiplier serve both signednesses.
    always_comb begin
        prod_full = 66'($signed({is_signed & a[31], a}) * $signed({is_signed & b[31], b}));
        prod = prod_full[63:0];
        if (subtract) begin
            sum = acc - prod;
        end else begin
            sum = acc + prod;
        end
    end

endmodule

`default_nettype wire

// file: ied_datapath.sv
// Purpose: Multiplies, swaps, extracts, special registers, block and exclusive moves.
// Assumes: Same-clock register file read port; memory holds request until ack.
// Notes: Single-cycle operations answer one cycle after acceptance.
`timescale 1ns/1ps
`default_nettype none
`include "ied_defs.svh"

module ied_datapath (
    input wire logic clk,
    input wire logic reset,
    input wire logic req_valid,
    output logic req_ready,
    input wire ied_pkg::ied_req_t req,
    output ied_pkg::ied_res_t res,
    output logic [3:0] flags,
    output logic primask,
    output logic [1:0] control,
    output logic [3:0] rf_rd_idx,
    input wire logic [31:0] rf_rd_data,
    output ied_pkg::ied_mem_t mem,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);

    // ======================================================================
    // State
    typedef enum logic [1:0] {
        ST_IDLE, ST_MULTI, ST_XLOAD, ST_XSTORE
    } ied_state_t;

    ied_state_t state_q;
    ied_pkg::ied_res_t res_q;
    ied_pkg::ied_mem_t mem_q;
    logic [3:0] flags_q;
    logic primask_q;
    logic [1:0] control_q;
    logic mstore_q;
    logic wback_q;
    logic [3:0] base_idx_q;
    logic [31:0] final_base_q;
    logic [15:0] remain_q;
    logic [3:0] cur_idx_q;
    logic [3:0] xdst_q;
    logic excl_mark_q;
    logic [31:0] excl_addr_q;

    logic take;
    logic excl_hit;
    logic [3:0] next_idx;
    logic [4:0] list_count;
    logic [31:0] list_bytes;
    logic [63:0] mac_acc;
    logic [63:0] mac_sum;
    logic mac_signed;
    logic mac_sub;
    logic [31:0] rotated;
    logic [31:0] field_sh;
    logic [5:0] field_pad;
    logic [31:0] field_left;
    logic [31:0] spec_rd;
    logic [15:0] remain_next;

    assign take = req_valid && (state_q == ST_IDLE);
    assign excl_hit = excl_mark_q && (excl_addr_q == req.a);
    assign req_ready = (state_q == ST_IDLE);
    assign res = res_q;
    assign flags = flags_q;
    assign primask = primask_q;
    assign control = control_q;
    assign mem = mem_q;
    assign rf_rd_idx = next_idx;

    // ======================================================================
    // Multiplier operand preparation
    // The addend differs per form so one adder covers every multiply.
    always_comb begin
        mac_acc = 64'h0;
        mac_signed = 1'b0;
        mac_sub = 1'b0;
        case (req.op)
            ied_pkg::OP_MAC: mac_acc = {32'h0, req.c};
            ied_pkg::OP_MSUB: begin
                mac_acc = {32'h0, req.c};
                mac_sub = 1'b1;
            end
            ied_pkg::OP_SWPROD: mac_signed = 1'b1;
            ied_pkg::OP_SWACC: begin
                mac_acc = {req.d, req.c};
                mac_signed = 1'b1;
            end
            ied_pkg::OP_UWDACC: mac_acc = {32'h0, req.c} + {32'h0, req.d};
            default: mac_acc = 64'h0;
        endcase
    end

    ied_mac u_mac (
        .a(req.a),
        .b(req.b),
        .acc(mac_acc),
        .is_signed(mac_signed),
        .subtract(mac_sub),
        .sum(mac_sum)
    );

    // ======================================================================
    // Rotation, field extraction and special-register read mux
    // A width of zero is not a legal field; it yields a result of zero.
    always_comb begin
        rotated = 32'({req.a, req.a} >> {req.rot, 3'b000});
        field_sh = req.a >> req.lsb;
        field_pad = 6'h20 - req.width;
        field_left = field_sh << field_pad;
        case (req.spec_sel)
            `IED_SPEC_STATUS: spec_rd = {flags_q, 28'h0};
            `IED_SPEC_PRIMASK: spec_rd = {31'h0, primask_q};
            `IED_SPEC_CONTROL: spec_rd = {30'h0, control_q};
            default: spec_rd = 32'h0;
        endcase
    end

    // ======================================================================
    // Register list walk
    // Lowest index at the lowest address; the block ends just below the base.
    always_comb begin
        next_idx = 4'h0;
        list_count = 5'h0;
        for (int i = 15; i >= 0; i--) begin
            if (remain_q[i]) begin
                next_idx = 4'(i);
            end
        end
        for (int j = 0; j < 16; j++) begin
            list_count = list_count + {4'h0, req.reglist[j]};
        end
        list_bytes = {25'h0, list_count, 2'b00};
        remain_next = remain_q & ~(16'h0001 << cur_idx_q);
    end

    // ======================================================================
    // Sequencer state
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (take && (req.op == ied_pkg::OP_MLOAD || req.op == ied_pkg::OP_MSTORE)) begin
                        state_q <= ST_MULTI;
                    end else if (take && req.op == ied_pkg::OP_XLOAD) begin
                        state_q <= ST_XLOAD;
                    end else if (take && req.op == ied_pkg::OP_XSTORE && excl_hit) begin
                        // A failing store answers at once and never waits for memory.
                        state_q <= ST_XSTORE;
                    end
                end
                ST_MULTI: begin
                    if ((remain_q == 16'h0 && !mem_q.req) ||
                        (mem_ack && remain_next == 16'h0)) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_XLOAD, ST_XSTORE: begin
                    if (mem_ack) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Block transfer bookkeeping
    always_ff @(posedge clk) begin
        if (reset) begin
            mstore_q <= 1'b0;
            wback_q <= 1'b0;
            base_idx_q <= 4'h0;
            final_base_q <= 32'h0;
            remain_q <= 16'h0;
            cur_idx_q <= 4'h0;
            xdst_q <= 4'h0;
        end else if (take) begin
            mstore_q <= (req.op == ied_pkg::OP_MSTORE);
            wback_q <= req.wback;
            base_idx_q <= req.base_idx;
            final_base_q <= req.a - list_bytes;
            remain_q <= req.reglist;
            xdst_q <= req.dst_lo;
        end else if (state_q == ST_MULTI) begin
            if (!mem_q.req && remain_q != 16'h0) begin
                cur_idx_q <= next_idx;
            end else if (mem_ack) begin
                remain_q <= remain_next;
            end
        end
    end

    // ======================================================================
    // Memory request
    // The request holds until acked; store data are latched at issue so
    // the register file read port is free while the beat is pending.
    always_ff @(posedge clk) begin
        if (reset) begin
            mem_q <= '0;
        end else if (take && (req.op == ied_pkg::OP_MLOAD || req.op == ied_pkg::OP_MSTORE)) begin
            mem_q.addr <= req.a - list_bytes;
            mem_q.size <= `IED_SIZE_WORD;
            mem_q.we <= (req.op == ied_pkg::OP_MSTORE);
        end else if (take && req.op == ied_pkg::OP_XLOAD) begin
            mem_q <= '{req: 1'b1, we: 1'b0, size: `IED_SIZE_HALF, addr: req.a,
                       wdata: 32'h0};
        end else if (take && req.op == ied_pkg::OP_XSTORE && excl_hit) begin
            mem_q <= '{req: 1'b1, we: 1'b1, size: `IED_SIZE_HALF, addr: req.a,
                       wdata: {16'h0, req.b[15:0]}};
        end else if (state_q == ST_MULTI && !mem_q.req && remain_q != 16'h0) begin
            mem_q.req <= 1'b1;
            mem_q.wdata <= rf_rd_data;
        end else if (mem_ack) begin
            mem_q.req <= 1'b0;
            mem_q.addr <= mem_q.addr + `IED_WORD_BYTES;
        end
    end

    // ======================================================================
    // Exclusive monitor
    // Any exclusive store, pass or fail, consumes the mark.
    always_ff @(posedge clk) begin
        if (reset) begin
            excl_mark_q <= 1'b0;
            excl_addr_q <= 32'h0;
        end else if (take && req.op == ied_pkg::OP_XLOAD) begin
            excl_mark_q <= 1'b1;
            excl_addr_q <= req.a;
        end else if (take && req.op == ied_pkg::OP_XSTORE) begin
            excl_mark_q <= 1'b0;
        end
    end

    // ======================================================================
    // Condition flags and special registers
    // Only the status write and flag-setting constant move touch the flags.
    always_ff @(posedge clk) begin
        if (reset) begin
            flags_q <= `IED_FLAGS_RST;
            primask_q <= `IED_PRIMASK_RST;
            control_q <= `IED_CONTROL_RST;
        end else if (take && req.op == ied_pkg::OP_WSPEC) begin
            case (req.spec_sel)
                `IED_SPEC_STATUS: flags_q <= req.a[31:28];
                `IED_SPEC_PRIMASK: primask_q <= req.a[0];
                `IED_SPEC_CONTROL: control_q <= req.a[1:0];
                default: flags_q <= flags_q;
            endcase
        end else if (take && req.op == ied_pkg::OP_WCMOVE && req.set_flags) begin
            flags_q[3] <= 1'b0;
            flags_q[2] <= (req.imm16 == 16'h0);
        end else begin
            flags_q <= flags_q;
        end
    end

    // ======================================================================
    // Write-back to the register file
    always_ff @(posedge clk) begin
        if (reset) begin
            res_q <= '0;
        end else begin
            res_q.wr_lo <= 1'b0;
            res_q.wr_hi <= 1'b0;
            if (take) begin
                res_q.idx_lo <= req.dst_lo;
                res_q.idx_hi <= req.dst_hi;
                res_q.wr_lo <= 1'b1;
                res_q.data_hi <= mac_sum[63:32];
                case (req.op)
                    ied_pkg::OP_MAC, ied_pkg::OP_MSUB: begin
                        res_q.data_lo <= mac_sum[31:0];
                    end
                    ied_pkg::OP_SWPROD, ied_pkg::OP_SWACC, ied_pkg::OP_UWDACC: begin
                        res_q.data_lo <= mac_sum[31:0];
                        res_q.wr_hi <= 1'b1;
                    end
                    ied_pkg::OP_BSWAP: begin
                        res_q.data_lo <= {req.a[7:0], req.a[15:8], req.a[23:16],
                                          req.a[31:24]};
                    end
                    ied_pkg::OP_HBSWAP: begin
                        res_q.data_lo <= {req.a[23:16], req.a[31:24], req.a[7:0],
                                          req.a[15:8]};
                    end
                    ied_pkg::OP_LHSWAP: begin
                        res_q.data_lo <= {{16{req.a[7]}}, req.a[7:0], req.a[15:8]};
                    end
                    ied_pkg::OP_SFX: begin
                        res_q.data_lo <= 32'($signed(field_left) >>> field_pad);
                    end
                    ied_pkg::OP_UFX: res_q.data_lo <= field_left >> field_pad;
                    ied_pkg::OP_HSWIDEN: begin
                        res_q.data_lo <= {{16{rotated[15]}}, rotated[15:0]};
                    end
                    ied_pkg::OP_HZWIDEN: res_q.data_lo <= {16'h0, rotated[15:0]};
                    ied_pkg::OP_RSPEC: res_q.data_lo <= spec_rd;
                    ied_pkg::OP_WCMOVE: res_q.data_lo <= {16'h0, req.imm16};
                    default: res_q.wr_lo <= 1'b0;
                endcase
                if (req.op == ied_pkg::OP_XSTORE && !excl_hit) begin
                    res_q.wr_lo <= 1'b1;
                    res_q.data_lo <= `IED_EXCL_FAIL;
                end
            end else if (state_q == ST_MULTI) begin
                if (!mstore_q && mem_ack) begin
                    res_q.wr_lo <= 1'b1;
                    res_q.idx_lo <= cur_idx_q;
                    res_q.data_lo <= mem_rdata;
                end
                if ((remain_q == 16'h0 && !mem_q.req) ||
                    (mem_ack && remain_next == 16'h0)) begin
                    res_q.wr_hi <= wback_q;
                    res_q.idx_hi <= base_idx_q;
                    res_q.data_hi <= final_base_q;
                end
            end else if (state_q == ST_XLOAD && mem_ack) begin
                res_q.wr_lo <= 1'b1;
                res_q.idx_lo <= xdst_q;
                res_q.data_lo <= {16'h0, mem_rdata[15:0]};
            end else if (state_q == ST_XSTORE && mem_ack) begin
                res_q.wr_lo <= 1'b1;
                res_q.idx_lo <= xdst_q;
                res_q.data_lo <= `IED_EXCL_PASS;
            end
        end
    end

endmodule

`default_nettype wire

// file: ied_datapath_assertions.sv
// Purpose: Port-level checks of the integer execution datapath.
// Assumes: Bound to ied_datapath; sees its ports only.
// Notes: A copy of each taken request ties the result one cycle later to its cause.
`timescale 1ns/1ps
`default_nettype none

module ied_datapath_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire ied_pkg::ied_req_t req,
    input wire ied_pkg::ied_res_t res,
    input wire logic [3:0] flags,
    input wire logic primask,
    input wire logic [1:0] control,
    input wire logic [3:0] rf_rd_idx,
    input wire logic [31:0] rf_rd_data,
    input wire ied_pkg::ied_mem_t mem,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // =======================================================================
    // Request copy, so a result can be compared with what caused it.
    ied_pkg::ied_req_t r_q;
    logic t_q;
    logic signed [63:0] sp;
    assign sp = $signed(r_q.a) * $signed(r_q.b);
    always_ff @(posedge clk) begin
        r_q <= req;
        t_q <= !reset && req_valid && req_ready;
    end

    // =======================================================================
    // Results one cycle after the take.
    chk_mac_value: assert property (t_q && r_q.op == ied_pkg::OP_MAC |->
        res.wr_lo && res.idx_lo == r_q.dst_lo && res.data_lo == r_q.a * r_q.b + r_q.c)
        else $error("mac value wrong");
    chk_msub_value: assert property (t_q && r_q.op == ied_pkg::OP_MSUB |->
        res.wr_lo && res.data_lo == r_q.c - r_q.a * r_q.b) else $error("msub value wrong");
    chk_wide_signed: assert property (t_q && r_q.op == ied_pkg::OP_SWPROD |->
        res.wr_hi && {res.data_hi, res.data_lo} == sp) else $error("wide product wrong");
    chk_swap_word: assert property (t_q && r_q.op == ied_pkg::OP_BSWAP |->
        res.data_lo == {r_q.a[7:0], r_q.a[15:8], r_q.a[23:16], r_q.a[31:24]})
        else $error("byte swap wrong");
    // Flags move only for a status write or a flag-setting move.
    chk_flags_kept: assert property (t_q && !(r_q.op == ied_pkg::OP_WSPEC &&
        r_q.spec_sel == 2'h0) && !(r_q.op == ied_pkg::OP_WCMOVE && r_q.set_flags)
        |-> $stable(flags)) else $error("flags changed");
    chk_status_write: assert property (t_q && r_q.op == ied_pkg::OP_WSPEC &&
        r_q.spec_sel == 2'h0 |-> flags == r_q.a[31:28]) else $error("status write wrong");
    chk_move_flags: assert property (t_q && r_q.op == ied_pkg::OP_WCMOVE &&
        r_q.set_flags |-> flags[3:2] == {1'b0, r_q.imm16 == 16'h0} && $stable(flags[1:0]))
        else $error("move flags wrong");
    // Memory side: requests stand until acknowledged.
    chk_mem_hold: assert property (mem.req && !mem_ack |=>
        mem.req && $stable(mem.addr)) else $error("memory request dropped");
    chk_store_busy: assert property (req_valid && req_ready &&
        req.op == ied_pkg::OP_MSTORE && req.reglist != 16'h0 |=> !req_ready [*2])
        else $error("ready during store");
    chk_xload_addr: assert property (t_q && r_q.op == ied_pkg::OP_XLOAD |->
        mem.req && !mem.we && mem.size == 2'h1 && mem.addr == r_q.a)
        else $error("exclusive load request wrong");
endmodule

bind ied_datapath ied_datapath_chk chk_u (.clk(clk), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .res(res), .flags(flags), .primask(primask),
    .control(control), .rf_rd_idx(rf_rd_idx), .rf_rd_data(rf_rd_data), .mem(mem),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

`default_nettype wire

// file: ied_env_model.sv
// Purpose: Register file read port and memory behind the datapath.
// Assumes: One request at a time, held by the datapath until ack.
// Notes: delay sets how many cycles the memory lets a request wait.
`timescale 1ns/1ps
`default_nettype none

module ied_env_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] delay,
    input wire ied_pkg::ied_mem_t mem,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    input wire logic [3:0] rf_rd_idx,
    output logic [31:0] rf_rd_data
);
    // =======================================================================
    // Each register reads as a marker plus its own index.
    logic [31:0] ram [16];
    logic [1:0] wait_q;
    assign rf_rd_data = {16'hC0DE, 12'h000, rf_rd_idx};
    // Outside ack the data inverts, so a stale sample cannot pass.
    assign mem_rdata = mem_ack ? ram[mem.addr[5:2]] : ~ram[mem.addr[5:2]];

    // Ack is a single pulse after the chosen wait.
    always_ff @(posedge clk) begin
        if (reset || !mem.req || mem_ack) begin
            mem_ack <= 1'b0;
            wait_q <= 2'h0;
        end else if (wait_q == delay) begin
            mem_ack <= 1'b1;
        end else begin
            wait_q <= wait_q + 2'h1;
        end
    end

    // Writes land at the ack edge, halfwords in their own lane.
    always_ff @(posedge clk) begin
        if (mem_ack && mem.we) begin
            if (mem.size != 2'h1) ram[mem.addr[5:2]] <= mem.wdata;
            else if (mem.addr[1]) ram[mem.addr[5:2]][31:16] <= mem.wdata[15:0];
            else ram[mem.addr[5:2]][15:0] <= mem.wdata[15:0];
        end
    end
endmodule

`default_nettype wire

// file: integer_execution_datapath_tb.sv
// Purpose: Self-checking bench of the integer execution datapath.
// Assumes: Inputs change on the falling edge only.
// Notes: Requests are spaced one idle cycle apart.
`timescale 1ns/1ps
`default_nettype none

module integer_execution_datapath_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    logic [1:0] delay = 2'h0;
    ied_pkg::ied_req_t req = '0;
    ied_pkg::ied_req_t r = '0;
    ied_pkg::ied_res_t res;
    ied_pkg::ied_mem_t mem;
    logic req_ready, primask, mem_ack;
    logic [3:0] flags, rf_rd_idx;
    logic [1:0] control;
    logic [31:0] rf_rd_data, mem_rdata, hi_v;
    logic [31:0] z = 32'h0;
    logic [31:0] ones = 32'hFFFF_FFFF;
    logic [31:0] lo_q[$];
    int mismatches = 0;
    int samples_checked = 0;

    always #10 clk = ~clk;

    ied_datapath dut_u (.clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .res(res), .flags(flags), .primask(primask), .control(control),
        .rf_rd_idx(rf_rd_idx), .rf_rd_data(rf_rd_data), .mem(mem), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    ied_env_model env_u (.clk(clk), .reset(reset), .delay(delay), .mem(mem),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rf_rd_idx(rf_rd_idx),
        .rf_rd_data(rf_rd_data));

    // =======================================================================
    // Tasks.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Offer a request and gather writes until idle again.
    task go(input ied_pkg::ied_op_t op, input logic [31:0] a = 32'h0, b = 32'h0,
            c = 32'h0, d = 32'h0);
        int n;
        r.op = op;
        r.a = a;
        r.b = b;
        r.c = c;
        r.d = d;
        lo_q = {};
        hi_v = 32'h0;
        @(negedge clk);
        req = r;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        for (n = 0; n < 60; n++) begin
            if (res.wr_lo === 1'b1) lo_q.push_back(res.data_lo);
            if (res.wr_hi === 1'b1) hi_v = res.data_hi;
            if (req_ready === 1'b1) break;
            @(negedge clk);
        end
    endtask

    task res1(input ied_pkg::ied_op_t op, input logic [31:0] exp, a = 32'h0, b = 32'h0,
              c = 32'h0, d = 32'h0);
        go(op, a, b, c, d);
        chk(lo_q[0], exp);
    endtask

    // A hang counts as a failure.
    initial begin
        #50000;
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end

    // =======================================================================
    // Test sequence.
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        chk({28'h0, flags}, z);
        res1(ied_pkg::OP_MAC, 32'h0005_001F, 32'h0001_0003, 32'h5, 32'h10);
        res1(ied_pkg::OP_MSUB, 32'hFFFF_FE00, 32'h3, 32'h100, 32'h100);
        res1(ied_pkg::OP_SWPROD, 32'hFFFF_FFFA, 32'hFFFF_FFFE, 32'h3);
        chk(hi_v, ones);
        res1(ied_pkg::OP_SWACC, 32'hA, 32'hFFFF_FFFE, 32'h3, 32'h10);
        chk(hi_v, z);
        res1(ied_pkg::OP_UWDACC, ones, ones, ones, ones, ones);
        chk(hi_v, ones);
        res1(ied_pkg::OP_BSWAP, 32'h4433_2211, 32'h1122_3344);
        res1(ied_pkg::OP_HBSWAP, 32'h2211_4433, 32'h1122_3344);
        res1(ied_pkg::OP_LHSWAP, 32'hFFFF_8033, 32'h1122_3380);
        r.lsb = 5'h4;
        r.width = 6'h8;
        r.rot = 2'h1;
        res1(ied_pkg::OP_SFX, 32'hFFFF_FFF8, 32'h0F80);
        res1(ied_pkg::OP_UFX, 32'hF8, 32'h0F80);
        res1(ied_pkg::OP_HSWIDEN, 32'hFFFF_8022, 32'h1180_2233);
        res1(ied_pkg::OP_HZWIDEN, 32'h8022, 32'h1180_2233);
        r.lsb = 5'h0;
        r.width = 6'h20;
        res1(ied_pkg::OP_UFX, 32'h8765_4321, 32'h8765_4321);
        $display("test arithmetic done");
        go(ied_pkg::OP_WSPEC, 32'hA000_0000);
        chk({28'h0, flags}, 32'hA);
        res1(ied_pkg::OP_MAC, 32'h7, 32'h2, 32'h3, 32'h1);
        chk({28'h0, flags}, 32'hA);
        r.imm16 = 16'h1234;
        res1(ied_pkg::OP_WCMOVE, 32'h1234);
        chk({28'h0, flags}, 32'hA);
        r.imm16 = 16'h0;
        r.set_flags = 1'b1;
        res1(ied_pkg::OP_WCMOVE, z);
        chk({28'h0, flags}, 32'h6);
        r.set_flags = 1'b0;
        res1(ied_pkg::OP_RSPEC, 32'h6000_0000);
        chk({28'h0, flags}, 32'h6);
        r.spec_sel = 2'h1;
        go(ied_pkg::OP_WSPEC, 32'h1);
        chk({31'h0, primask}, 32'h1);
        r.spec_sel = 2'h2;
        go(ied_pkg::OP_WSPEC, 32'h3);
        chk({30'h0, control}, 32'h3);
        chk({28'h0, flags}, 32'h6);
        $display("test special registers done");
        r.reglist = 16'h000A;
        r.wback = 1'b1;
        r.base_idx = 4'hD;
        go(ied_pkg::OP_MSTORE, 32'h100);
        chk(hi_v, 32'hF8);
        delay = 2'h2;
        go(ied_pkg::OP_MLOAD, 32'h100);
        chk(lo_q[0], 32'hC0DE_0001);
        chk(lo_q[1], 32'hC0DE_0003);
        chk(hi_v, 32'hF8);
        $display("test block transfer done");
        r.dst_lo = 4'h2;
        res1(ied_pkg::OP_XLOAD, 32'h1, 32'hF8);
        res1(ied_pkg::OP_XSTORE, z, 32'hF8, 32'hBEEF);
        res1(ied_pkg::OP_XSTORE, 32'h1, 32'hF8, 32'h1);
        res1(ied_pkg::OP_XLOAD, 32'hBEEF, 32'hF8);
        $display("test exclusive done");
        conclude();
    end
endmodule

`default_nettype wire
